// [common/uass_pkg.sv]
/*
  uass_pkg: constants and carrier types for the usb audio stream sequencer.
  assumes a single 100 MHz clock domain; the suspend and reset times are converted to cycles here.
*/
package uass_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS    = 10000;            // 100 MHz
  localparam int unsigned SUSPEND_IDLE_US  = 5000;             // about 5 ms of idle
  localparam int unsigned RESET_RELEASE_US = 700;              // internal reset hold
  // cycles per microsecond first, so the product stays inside 32 bits
  localparam int unsigned SUSPEND_IDLE_CYC =
    SUSPEND_IDLE_US * (1000000 / CLK_PERIOD_PS);               // least time, exact
  localparam int unsigned RESET_RELEASE_CYC =
    RESET_RELEASE_US * (1000000 / CLK_PERIOD_PS);
  localparam int unsigned FRAME_US         = 1000;             // one packet of audio

  // ----------------------------------------------------------------
  // sample format and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SAMPLE_W = 16;
  localparam logic [15:0] MIDSCALE_ZERO = 16'h0000;            // bipolar zero, 2s complement

  // ----------------------------------------------------------------
  // playback states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UASS_PB_IDLE  = 2'b00,  // waiting for first packet
    UASS_PB_ARMED = 2'b01,  // packet buffered, waiting for sof
    UASS_PB_PLAY  = 2'b10,  // streaming samples out
    UASS_PB_DRAIN = 2'b11   // host stopped, emptying buffer
  } uass_pb_state_t;

  // stereo sample pair
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } uass_sample_t;

  // bus event strobes from the protocol engine
  typedef struct packed {
    logic sof;           // start-of-frame seen
    logic pkt_done;      // playback packet fully written
    logic play_stop;     // host ended or aborted playback
    logic rec_select;    // set_interface selecting record alt setting
    logic rec_release;   // set_interface back to zero bandwidth
  } uass_events_t;

endpackage : uass_pkg

// [hw/uass_sequencer.sv]
/*
  uass_sequencer: playback/record sequencing and suspend control of a usb audio function.
  assumes the protocol engine and sample buffer side run on ref_clk_in and present
  one-cycle event strobes; line state and power-on detect are asynchronous pins.
*/
`timescale 1ns/1ps

module uass_sequencer
  import uass_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES  = SUSPEND_IDLE_CYC,
  parameter int unsigned RESET_CYCLES = RESET_RELEASE_CYC,
  parameter int unsigned BUF_DEPTH    = 64
) (
  // clock and reset
  input  wire logic          ref_clk_in,
  input  wire logic          reset_n_in,
  // pins from outside the domain
  input  wire logic          power_good_in,     // power-on detector fired
  input  wire logic          bus_attached_in,   // attach seen on the bus
  input  wire logic          bus_idle_in,       // line state is idle (j)
  // protocol engine events and data
  input  wire uass_events_t  events_in,
  input  wire logic          pkt_wr_in,         // playback sample write strobe
  input  wire uass_sample_t  pkt_data_in,
  input  wire logic          sample_tick_in,    // one-cycle sample rate enable
  // outputs
  output logic               seq_ready_out,     // internal reset released, attached
  output uass_sample_t       sample_out,
  output logic               playing_out,
  output logic               capture_en_out,
  output logic               suspend_flag_n_out
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // refuse counts the counters cannot serve and non power-of-two depths
  if (IDLE_CYCLES < 2 || RESET_CYCLES < 1 || BUF_DEPTH < 2 ||
      (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_param_check
    $error("uass_sequencer: unsupported parameter values");
  end

  localparam int unsigned AW = $clog2(BUF_DEPTH);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {power_good_in, bus_attached_in, bus_idle_in};
      sync_b <= sync_a;
    end
  end
  logic pwr_s;
  logic att_s;
  logic idle_s;
  assign pwr_s  = sync_b[2];
  assign att_s  = sync_b[1];
  assign idle_s = sync_b[0];

  // ----------------------------------------------------------------
  // internal reset release
  // ----------------------------------------------------------------
  logic [$clog2(RESET_CYCLES+1)-1:0] rst_cnt;
  logic                              int_rel;
  // count from power-good until release, restart if power drops
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_cnt <= '0;
      int_rel <= 1'b0;
    end else if (!pwr_s) begin
      rst_cnt <= '0;
      int_rel <= 1'b0;
    end else if (rst_cnt == ($clog2(RESET_CYCLES+1))'(RESET_CYCLES - 1)) begin
      int_rel <= 1'b1;
    end else if (!int_rel) begin
      rst_cnt <= rst_cnt + 1'b1;
    end
  end

  logic active;
  assign active = int_rel && att_s;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) seq_ready_out <= 1'b0;
    else             seq_ready_out <= active;
  end

  // ----------------------------------------------------------------
  // playback buffer
  // ----------------------------------------------------------------
  uass_sample_t  buf_mem [BUF_DEPTH];
  logic [AW:0]   wr_ptr;
  logic [AW:0]   rd_ptr;
  logic          buf_empty;
  logic          buf_full;
  logic          rd_en;
  uass_pb_state_t pb_state;
  assign buf_empty = (wr_ptr == rd_ptr);
  assign buf_full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign rd_en     = sample_tick_in && !buf_empty &&
                     (pb_state == UASS_PB_PLAY || pb_state == UASS_PB_DRAIN);

  // packet samples land in the buffer; writes beyond full are dropped
  always_ff @(posedge ref_clk_in) begin
    if (pkt_wr_in && !buf_full && active)
      buf_mem[wr_ptr[AW-1:0]] <= pkt_data_in;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (!active) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (pkt_wr_in && !buf_full) wr_ptr <= wr_ptr + 1'b1;
      if (rd_en)                  rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // playback state machine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pb_state <= UASS_PB_IDLE;
    end else if (!active) begin
      pb_state <= UASS_PB_IDLE;
    end else begin
      unique case (pb_state)
        UASS_PB_IDLE: begin
          if (events_in.pkt_done && !buf_empty) pb_state <= UASS_PB_ARMED;
        end
        UASS_PB_ARMED: begin
          if (events_in.play_stop)   pb_state <= UASS_PB_DRAIN;
          else if (events_in.sof)    pb_state <= UASS_PB_PLAY;
        end
        UASS_PB_PLAY: begin
          if (events_in.play_stop)   pb_state <= UASS_PB_DRAIN;
        end
        UASS_PB_DRAIN: begin
          if (buf_empty)             pb_state <= UASS_PB_IDLE;
        end
      endcase
    end
  end

  // sample output: buffered data on each tick while playing, midscale on an empty tick or when idle or armed
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sample_out <= '{left: MIDSCALE_ZERO, right: MIDSCALE_ZERO};
    end else if (rd_en) begin
      sample_out <= buf_mem[rd_ptr[AW-1:0]];
    end else if (sample_tick_in || pb_state == UASS_PB_IDLE ||
                 pb_state == UASS_PB_ARMED) begin
      sample_out <= '{left: MIDSCALE_ZERO, right: MIDSCALE_ZERO};
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) playing_out <= 1'b0;
    else playing_out <= (pb_state == UASS_PB_PLAY || pb_state == UASS_PB_DRAIN);
  end

  // ----------------------------------------------------------------
  // record capture enable
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in)                 capture_en_out <= 1'b0;
    else if (!active)                capture_en_out <= 1'b0;
    else if (events_in.rec_select)   capture_en_out <= 1'b1;
    else if (events_in.rec_release)  capture_en_out <= 1'b0;
  end

  // ----------------------------------------------------------------
  // suspend detection
  // ----------------------------------------------------------------
  logic [$clog2(IDLE_CYCLES+1)-1:0] idle_cnt;
  logic                             suspended;
  // counts continuous idle; any non-idle sample clears it at once
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      idle_cnt  <= '0;
      suspended <= 1'b0;
    end else if (!idle_s || !active) begin
      idle_cnt  <= '0;
      suspended <= 1'b0;
    end else if (idle_cnt == ($clog2(IDLE_CYCLES+1))'(IDLE_CYCLES - 1)) begin
      suspended <= 1'b1;
    end else begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) suspend_flag_n_out <= 1'b1;
    else             suspend_flag_n_out <= !suspended;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_armed_sof;
    pb_state == UASS_PB_ARMED && events_in.sof && !events_in.play_stop && active;
  endsequence
  property p_start_on_sof;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      s_armed_sof |=> pb_state == UASS_PB_PLAY ##1 playing_out;
  endproperty
  a_start_on_sof: assert property (p_start_on_sof) else $error("play not on sof");

  property p_no_play_before_sof;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (pb_state == UASS_PB_PLAY && $past(pb_state) != UASS_PB_PLAY) |->
        $past(pb_state) == UASS_PB_ARMED && $past(events_in.sof);
  endproperty
  a_no_play_before_sof: assert property (p_no_play_before_sof) else $error("play early");

  property p_drain_ends;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (pb_state == UASS_PB_DRAIN && buf_empty && active) |=> pb_state == UASS_PB_IDLE;
  endproperty
  a_drain_ends: assert property (p_drain_ends) else $error("drain did not stop");

  property p_drain_holds;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (pb_state == UASS_PB_DRAIN && !buf_empty && active) |=> pb_state == UASS_PB_DRAIN;
  endproperty
  a_drain_holds: assert property (p_drain_holds) else $error("stopped with data left");

  property p_capture_after_select;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $rose(capture_en_out) |-> $past(events_in.rec_select);
  endproperty
  a_capture_after_select: assert property (p_capture_after_select) else $error("capture early");

  property p_suspend_time;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $rose(suspended) |-> idle_cnt == ($clog2(IDLE_CYCLES+1))'(IDLE_CYCLES - 1);
  endproperty
  a_suspend_time: assert property (p_suspend_time) else $error("suspend timing wrong");

  property p_flag_follows;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      suspended |=> !suspend_flag_n_out;
  endproperty
  a_flag_follows: assert property (p_flag_follows) else $error("flag not asserted");

  property p_wake;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (suspended && !idle_s) |=> !suspended ##1 suspend_flag_n_out;
  endproperty
  a_wake: assert property (p_wake) else $error("no immediate wake");

  property p_midscale_idle;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (pb_state == UASS_PB_IDLE) [*2] |-> sample_out == {MIDSCALE_ZERO, MIDSCALE_ZERO};
  endproperty
  a_midscale_idle: assert property (p_midscale_idle) else $error("output not midscale");

  property p_ready_gate;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      seq_ready_out |-> $past(int_rel) && $past(att_s);
  endproperty
  a_ready_gate: assert property (p_ready_gate) else $error("ready too early");

endmodule : uass_sequencer

// [verif/uass_host_model.sv]
/*
  uass_host_model: far-side host controller, framing the bus and idling it on request.
  assumes one clock shared with the sequencer; the bench enables frames and idle.
*/
`timescale 1ns/1ps

module uass_host_model #(
  parameter int unsigned SOF_PERIOD = 40
) (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  // control from the bench
  input  wire logic sof_en_in,
  input  wire logic idle_req_in,
  // bus side seen by the device
  output logic      sof_out,
  output logic      bus_idle_out
);
  int unsigned frame_cnt;

  // one start-of-frame pulse per frame while the host runs the bus
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame_cnt <= 0;
      sof_out   <= 1'b0;
    end else begin
      frame_cnt <= (sof_en_in && frame_cnt < SOF_PERIOD - 1) ? frame_cnt + 1 : 0;
      sof_out   <= sof_en_in && frame_cnt == SOF_PERIOD - 1;
    end
  end

  // line held in idle only when asked, released one cycle after the request drops; sof pulses do not break it
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_idle_out <= 1'b0;
    end else begin
      bus_idle_out <= idle_req_in;
    end
  end
endmodule : uass_host_model

// [verif/uass_sequencer_bench.sv]
/*
  uass_sequencer_bench: self-checking bench of the stream sequencer and host model.
  assumes short counts (idle 20, reset 10 cycles) and a 100 MHz clock.
*/
`timescale 1ns/1ps

module uass_sequencer_bench;
  import uass_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int unsigned IDLE_N = 20;
  localparam int unsigned RST_N  = 10;
  logic         ref_clk_in = 1'b0;
  logic         reset_n_in = 1'b0;
  logic         power_good = 1'b0;
  logic         attached   = 1'b0;
  logic         sof_en     = 1'b0;
  logic         idle_req   = 1'b0;
  logic         pkt_wr     = 1'b0;
  logic         tick       = 1'b0;
  logic         tick_d     = 1'b0;
  logic         live       = 1'b0;
  logic         bus_idle, host_sof, ready, playing, capture, flag_n;
  uass_events_t ev         = '0;
  uass_events_t ev_all;
  uass_sample_t pkt_data   = '0;
  uass_sample_t sample;
  logic [31:0]  d;
  logic [31:0]  exp_q[$];
  logic [31:0]  buf_q[$];
  logic [1:0]   rec_tab[3] = '{2'h2, 2'h1, 2'h3};
  int           bad_count  = 0;
  int           compares   = 0;
  int           n;

  assign ev_all = ev | uass_events_t'({host_sof, 4'h0});
  always #5 ref_clk_in = ~ref_clk_in;

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  uass_sequencer #(.IDLE_CYCLES(IDLE_N), .RESET_CYCLES(RST_N), .BUF_DEPTH(64)) i_uass_sequencer (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .power_good_in(power_good),
    .bus_attached_in(attached), .bus_idle_in(bus_idle), .events_in(ev_all),
    .pkt_wr_in(pkt_wr), .pkt_data_in(pkt_data), .sample_tick_in(tick),
    .seq_ready_out(ready), .sample_out(sample), .playing_out(playing),
    .capture_en_out(capture), .suspend_flag_n_out(flag_n));
  uass_host_model #(.SOF_PERIOD(40)) i_uass_host_model (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .sof_en_in(sof_en),
    .idle_req_in(idle_req), .sof_out(host_sof), .bus_idle_out(bus_idle));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_in);
  endtask : cyc

  // one sample tick; notes the pair the output must show next
  task automatic do_tick();
    tick <= 1'b1;
    if (live && buf_q.size() > 0) begin
      exp_q.push_back(buf_q.pop_front());
    end else begin
      exp_q.push_back(32'h0);
    end
    cyc(1);
    tick <= 1'b0;
    cyc(1);
  endtask : do_tick

  // ----------------------------------------------------------------
  // output watcher: oldest note against the sample after each tick
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    tick_d <= tick;
    if (tick_d) begin
      check(sample, exp_q.pop_front());
    end
  end

  // hang guard
  initial begin
    cyc(20000);
    bad_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hBB25));
    cyc(4);
    reset_n_in <= 1'b1;
    attached   <= 1'b1;
    cyc(1);
    check({28'h0, ready, playing, capture, flag_n}, 32'h1);
    // internal reset hold before sequencing may start
    power_good <= 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    check(n >= RST_N && n <= RST_N + 6, 1'b1);
    // waiting for data: output rests at midscale
    do_tick();
    do_tick();
    // back-to-back writes of one packet, then its completion
    repeat (4) begin
      d = $urandom;
      buf_q.push_back(d);
      pkt_data <= d;
      pkt_wr   <= 1'b1;
      cyc(1);
    end
    pkt_wr      <= 1'b0;
    ev.pkt_done <= 1'b1;
    cyc(1);
    ev.pkt_done <= 1'b0;
    cyc(20);
    do_tick();
    check(playing, 1'b0);
    // start of frame begins playback
    sof_en <= 1'b1;
    n = 0;
    while (playing !== 1'b1 && n < 50) begin
      cyc(1);
      n++;
    end
    check(n < 50, 1'b1);
    sof_en <= 1'b0;
    live = 1'b1;
    do_tick();
    // host stop: remaining pairs play out, then midscale
    ev.play_stop <= 1'b1;
    cyc(1);
    ev.play_stop <= 1'b0;
    cyc(2);
    check(playing, 1'b1);
    repeat (4) do_tick();
    n = 0;
    while (playing !== 1'b0 && n < 10) begin
      cyc(1);
      n++;
    end
    check(n < 10, 1'b1);
    live = 1'b0;
    do_tick();
    // record select, release, both at once
    check(capture, 1'b0);
    foreach (rec_tab[i]) begin
      {ev.rec_select, ev.rec_release} <= rec_tab[i];
      cyc(1);
      ev <= '0;
      cyc(1);
      check(capture, rec_tab[i][1]);
    end
    // detach clears readiness and capture; re-attach restores readiness
    attached <= 1'b0;
    cyc(5);
    check({ready, capture}, 2'h0);
    attached <= 1'b1;
    cyc(5);
    check(ready, 1'b1);
    // idle bus: suspend after the idle time, wake on traffic
    idle_req <= 1'b1;
    cyc(IDLE_N);
    check(flag_n, 1'b1);
    cyc(10);
    check(flag_n, 1'b0);
    cyc(30);
    check(flag_n, 1'b0);
    idle_req <= 1'b0;
    cyc(6);
    check(flag_n, 1'b1);
    print_verdict();
  end
endmodule : uass_sequencer_bench
